/* pkg/lcdsd_regs.svh */
`ifndef LCDSD_REGS_SVH
`define LCDSD_REGS_SVH

// ********************************
// frame layout
// ********************************
`define LCDSD_SEL_BIT_SHORT     21
`define LCDSD_SEL_BIT_LONG      33
`define LCDSD_LOAD_PULSE_SHORT  23
`define LCDSD_LOAD_PULSE_LONG   35
`define LCDSD_IND_A_BIT         31
`define LCDSD_IND_B_BIT         32
`define LCDSD_SEG_MASK_40       32'h000fffff
`define LCDSD_SEG_MASK_60       32'h3fffffff
`define LCDSD_SEG_MASK_FULL     32'hffffffff

// ********************************
// timing
// ********************************
`define LCDSD_CLK_HZ            100000000
`define LCDSD_FRAME_HZ          75
`define LCDSD_STEPS_PER_FRAME   4

`endif

/* pkg/lcdsd_pkg.sv */
package lcdsd_pkg;

  // display variants: segment count and backplane count
  typedef enum {
    LCDSD_V40,
    LCDSD_V60,
    LCDSD_V64,
    LCDSD_V32
  } lcdsd_variant_type;

  // receive word, bit n of the frame at index n
  typedef logic [33:0] lcdsd_word_type;

endpackage

/* rtl/lcdsd_link.sv */
`include "lcdsd_regs.svh"

module lcdsd_link import lcdsd_pkg::*; #(
  parameter logic [5:0] WORD_LEN = 6'd34
) (
  input  wire logic     clk_link_in,
  input  wire logic     rst_in,
  input  wire logic     data_line_in,
  input  wire logic     line_enable_in,
  output lcdsd_word_type word_out,
  output logic          word_ok_out,
  output logic          load_toggle_out
);

  logic           rst_meta;
  logic           rst_link;
  logic           prev_en;
  logic           lz_bad;
  logic           dis_bad;
  logic           last_data;
  logic           data_neg;
  logic [5:0]     count;
  lcdsd_word_type shreg;
  logic           next_prev_en;
  logic           next_lz_bad;
  logic           next_dis_bad;
  logic [5:0]     next_count;
  lcdsd_word_type next_shreg;
  lcdsd_word_type next_word;
  logic           next_ok;
  logic           next_toggle;

  // ********************************
  // frame receiver
  // ********************************

  // reset takes hold at once but lets go only on the second burst edge,
  // so a release never lands mid-pulse; the host clocks twice first
  always_ff @(posedge clk_link_in or posedge rst_in) begin
    if (rst_in) begin
      rst_meta <= 1'b1;
      rst_link <= 1'b1;
    end else begin
      rst_meta <= 1'b0;
      rst_link <= rst_meta;
    end
  end

  // data must hold through the high phase; caught again on the fall
  always_ff @(negedge clk_link_in) begin
    data_neg <= data_line_in;
  end

  // shift, count and check on each burst clock pulse
  always_comb begin
    next_prev_en = line_enable_in;
    next_lz_bad  = lz_bad;
    next_dis_bad = dis_bad;
    next_count   = count;
    next_shreg   = shreg;
    next_word    = word_out;
    next_ok      = word_ok_out;
    next_toggle  = load_toggle_out;
    if (line_enable_in && !prev_en) begin
      next_lz_bad  = data_line_in;
      next_dis_bad = 1'b0;
      next_count   = 6'd1;
      next_shreg   = '0;
    end else if (line_enable_in) begin
      next_shreg   = shreg | (lcdsd_word_type'(data_line_in) << count);
      next_count   = (count == 6'h3f) ? count : count + 6'd1;
      next_dis_bad = dis_bad | (last_data != data_neg);
    end else if (prev_en) begin
      // load pulse with enable low closes the frame
      next_word   = shreg;
      next_ok     = !lz_bad && !dis_bad && (last_data == data_neg)
                    && (count == WORD_LEN);
      next_toggle = !load_toggle_out;
    end
  end

  // held in reset with the system side, so the toggle never shows a false load
  always_ff @(posedge clk_link_in or posedge rst_link) begin
    if (rst_link) begin
      prev_en         <= 1'b0;
      lz_bad          <= 1'b0;
      dis_bad         <= 1'b0;
      last_data       <= 1'b0;
      count           <= 6'h00;
      shreg           <= '0;
      word_out        <= '0;
      word_ok_out     <= 1'b0;
      load_toggle_out <= 1'b0;
    end else begin
      prev_en         <= next_prev_en;
      lz_bad          <= next_lz_bad;
      dis_bad         <= next_dis_bad;
      last_data       <= data_line_in;
      count           <= next_count;
      shreg           <= next_shreg;
      word_out        <= next_word;
      word_ok_out     <= next_ok;
      load_toggle_out <= next_toggle;
    end
  end

  a_lead_zero: assert property (
    @(posedge clk_link_in) disable iff (rst_link)
    (line_enable_in && !prev_en && data_line_in) |=> lz_bad)
    else $error("set leading zero not flagged");

  a_count_fail: assert property (
    @(posedge clk_link_in) disable iff (rst_link)
    (!line_enable_in && prev_en && count != WORD_LEN) |=> !word_ok_out)
    else $error("wrong bit count accepted");

endmodule

/* rtl/lcdsd_top.sv */
// Operation
// - segment or indicator output is active when its received bit is one
// - 22-bit variant: bit 21 one loads first set, zero second set
// - 22-bit variant: pulse 23 copies shift register into chosen set
// - 34-bit two-backplane variants: bit 33 selects first or second set
// - 34-bit variants: pulse 35 copies shift register into chosen set
// - indicator variant: bits 31 and 32 set indicators on first-set load
// - indicator variant: second-set load leaves indicators unchanged
// - single-backplane variant loads only when bit 33 is one
// - a frame without leading zero fails
// - a frame with the wrong bit count fails
// - disturbance on enable or data during a frame fails it
// - load condition is a burst pulse with enable low
// - failed frame: load ignored, latches kept, ready for next frame
// - oscillator tied low: backplanes become inputs, timing follows master
// - single-backplane variant masters only single-backplane slaves
// - power-on reset clears latches and bus state
`include "lcdsd_regs.svh"

module lcdsd_top import lcdsd_pkg::*; #(
  parameter lcdsd_variant_type VARIANT         = LCDSD_V60,
  parameter int unsigned       OSC_STEP_CYCLES =
    `LCDSD_CLK_HZ / (`LCDSD_FRAME_HZ * `LCDSD_STEPS_PER_FRAME)
) (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_IN,
  input  wire logic        BURST_CLOCK_LINE_IN,
  input  wire logic        DATA_LINE_IN,
  input  wire logic        LINE_ENABLE_IN,
  input  wire logic        OSC_GROUNDED_IN,
  input  wire logic        FIRST_BACKPLANE_IN,
  input  wire logic        SECOND_BACKPLANE_IN,
  output logic             FIRST_BACKPLANE_OUT,
  output logic             FIRST_BACKPLANE_OE_N_OUT,
  output logic             SECOND_BACKPLANE_OUT,
  output logic             SECOND_BACKPLANE_OE_N_OUT,
  output logic [31:0]      SEGMENT_OUTPUTS_OUT,
  output logic             INDICATOR_OUTPUT_A_OUT,
  output logic             INDICATOR_OUTPUT_B_OUT,
  output logic             FRAME_REJECT_OUT
);

  // ********************************
  // variant constants
  // ********************************
  localparam bit TWO_BP = (VARIANT != LCDSD_V32);
  localparam bit SHORT  = (VARIANT == LCDSD_V40);
  localparam logic [5:0] WORD_LEN = SHORT ?
    6'(`LCDSD_LOAD_PULSE_SHORT - 1) : 6'(`LCDSD_LOAD_PULSE_LONG - 1);
  localparam int SEL_BIT = SHORT ? `LCDSD_SEL_BIT_SHORT : `LCDSD_SEL_BIT_LONG;
  localparam logic [31:0] SEG_MASK = SHORT ? `LCDSD_SEG_MASK_40 :
    (VARIANT == LCDSD_V60) ? `LCDSD_SEG_MASK_60 : `LCDSD_SEG_MASK_FULL;
  localparam logic [31:0] STEP_LAST = 32'(OSC_STEP_CYCLES - 1);

  lcdsd_word_type link_word;
  logic           link_ok;
  logic           link_toggle;

  // ********************************
  // link side receiver
  // ********************************
  lcdsd_link #(
    .WORD_LEN (WORD_LEN)
  ) u_link (
    .clk_link_in     (BURST_CLOCK_LINE_IN),
    .rst_in          (RST_IN),
    .data_line_in    (DATA_LINE_IN),
    .line_enable_in  (LINE_ENABLE_IN),
    .word_out        (link_word),
    .word_ok_out     (link_ok),
    .load_toggle_out (link_toggle)
  );

  // ********************************
  // crossings and pin synchronisers
  // ********************************
  logic       tgl_meta, tgl_sync, tgl_prev;
  logic       en_meta, en_sync, en_prev;
  logic       osc_meta, slave;
  logic       bp1_meta, bp1_sync, bp2_meta, bp2_sync;

  // load event crosses as a toggle; the word holds until the next frame
  // the link clears its toggle on the same reset, so no false edge follows
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      tgl_meta <= 1'b0;
      tgl_sync <= 1'b0;
      tgl_prev <= 1'b0;
      en_meta  <= 1'b0;
      en_sync  <= 1'b0;
      en_prev  <= 1'b0;
      osc_meta <= 1'b0;
      slave    <= 1'b0;
      bp1_meta <= 1'b0;
      bp1_sync <= 1'b0;
      bp2_meta <= 1'b0;
      bp2_sync <= 1'b0;
    end else begin
      tgl_meta <= link_toggle;
      tgl_sync <= tgl_meta;
      tgl_prev <= tgl_sync;
      en_meta  <= LINE_ENABLE_IN;
      en_sync  <= en_meta;
      en_prev  <= en_sync;
      osc_meta <= OSC_GROUNDED_IN;
      slave    <= osc_meta;
      bp1_meta <= FIRST_BACKPLANE_IN;
      bp1_sync <= bp1_meta;
      bp2_meta <= SECOND_BACKPLANE_IN;
      bp2_sync <= bp2_meta;
    end
  end

  // ********************************
  // frame checks and latch load
  // ********************************
  logic        load_evt, en_rise, glitch, sel, commit;
  logic [1:0]  rise_cnt, next_rise_cnt;
  logic [31:0] first_latch, second_latch, next_first, next_second;
  logic        ind_a, ind_b, next_ind_a, next_ind_b, next_reject;

  assign load_evt = tgl_sync != tgl_prev;
  assign en_rise  = en_sync && !en_prev;
  assign glitch   = rise_cnt > 2'd1;
  assign sel      = link_word[SEL_BIT];
  assign commit   = load_evt && link_ok && !glitch;

  // enable rising twice in one frame means a broken enable
  // a rise in the load cycle opens the next frame, so it is kept
  always_comb begin
    next_rise_cnt = rise_cnt;
    if (load_evt) begin
      next_rise_cnt = {1'b0, en_rise};
    end else if (en_rise && rise_cnt != 2'd3) begin
      next_rise_cnt = rise_cnt + 2'd1;
    end
  end

  // failed frames fall through untouched
  // a frame refused on the link side or by an enable glitch changes nothing
  always_comb begin
    next_first  = first_latch;
    next_second = second_latch;
    next_ind_a  = ind_a;
    next_ind_b  = ind_b;
    next_reject = load_evt && !commit;
    if (commit && sel) begin
      next_first = link_word[32:1] & SEG_MASK;
      if (VARIANT == LCDSD_V60) begin
        next_ind_a = link_word[`LCDSD_IND_A_BIT];
        next_ind_b = link_word[`LCDSD_IND_B_BIT];
      end
    end else if (commit && TWO_BP) begin
      next_second = link_word[32:1] & SEG_MASK;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      rise_cnt         <= 2'd0;
      first_latch      <= 32'h00000000;
      second_latch     <= 32'h00000000;
      ind_a            <= 1'b0;
      ind_b            <= 1'b0;
      FRAME_REJECT_OUT <= 1'b0;
    end else begin
      rise_cnt         <= next_rise_cnt;
      first_latch      <= next_first;
      second_latch     <= next_second;
      ind_a            <= next_ind_a;
      ind_b            <= next_ind_b;
      FRAME_REJECT_OUT <= next_reject;
    end
  end

  // ********************************
  // oscillator and display drive
  // ********************************
  logic [31:0] step_cnt, next_step_cnt;
  logic        osc_phase, osc_slot, next_osc_phase, next_osc_slot;
  logic        phase, slot;
  logic [31:0] next_seg;

  // divider stands in for the rc oscillator
  always_comb begin
    next_step_cnt  = step_cnt + 32'd1;
    next_osc_phase = osc_phase;
    next_osc_slot  = osc_slot;
    if (step_cnt >= STEP_LAST) begin
      next_step_cnt = 32'd0;
      if (TWO_BP) begin
        next_osc_slot  = !osc_slot;
        next_osc_phase = osc_phase ^ osc_slot;
      end else begin
        next_osc_phase = !osc_phase;
      end
    end
  end

  // a slave reads phase off bp1 and slot off bp1 xor bp2
  assign phase = slave ? bp1_sync : osc_phase;
  assign slot  = TWO_BP && (slave ? (bp1_sync ^ bp2_sync) : osc_slot);

  // lit segment runs out of phase with the first backplane in both slots
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      next_seg[i] = SEG_MASK[i] &&
                    (phase ^ (slot ? second_latch[i] : first_latch[i]));
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      step_cnt                  <= 32'd0;
      osc_phase                 <= 1'b0;
      osc_slot                  <= 1'b0;
      SEGMENT_OUTPUTS_OUT       <= 32'h00000000;
      FIRST_BACKPLANE_OUT       <= 1'b0;
      SECOND_BACKPLANE_OUT      <= 1'b0;
      FIRST_BACKPLANE_OE_N_OUT  <= 1'b1;
      SECOND_BACKPLANE_OE_N_OUT <= 1'b1;
      INDICATOR_OUTPUT_A_OUT    <= 1'b0;
      INDICATOR_OUTPUT_B_OUT    <= 1'b0;
    end else begin
      step_cnt                  <= next_step_cnt;
      osc_phase                 <= next_osc_phase;
      osc_slot                  <= next_osc_slot;
      SEGMENT_OUTPUTS_OUT       <= next_seg;
      FIRST_BACKPLANE_OUT       <= phase;
      SECOND_BACKPLANE_OUT      <= TWO_BP && (phase ^ slot);
      FIRST_BACKPLANE_OE_N_OUT  <= slave;
      SECOND_BACKPLANE_OE_N_OUT <= slave || !TWO_BP;
      INDICATOR_OUTPUT_A_OUT    <= ind_a;
      INDICATOR_OUTPUT_B_OUT    <= ind_b;
    end
  end

  // ********************************
  // checks
  // ********************************
  // all checks below run on the system clock and mute during reset, except a_reset_clear
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);

  sequence s_good_load;
    load_evt && link_ok && !glitch;
  endsequence

  // the reject pulse stands in the cycle right after the refused load event
  sequence s_bad_load;
    load_evt && (!link_ok || glitch);
  endsequence

  a_first_load: assert property (
    s_good_load and sel |=> first_latch == ($past(link_word[32:1]) & SEG_MASK))
    else $error("first set not loaded");

  a_second_load: assert property (
    s_good_load and !sel |=> second_latch == (TWO_BP ?
      ($past(link_word[32:1]) & SEG_MASK) : 32'h00000000))
    else $error("second set not loaded");

  a_fail_hold: assert property (
    s_bad_load |=> $stable(first_latch) && $stable(second_latch) && FRAME_REJECT_OUT)
    else $error("failed frame changed latches");

  a_single_skip: assert property (
    s_good_load and (!sel && !TWO_BP) |=> $stable(first_latch))
    else $error("single set loaded on zero");

  a_ind_keep: assert property (
    load_evt && !sel |=> $stable(ind_a) && $stable(ind_b))
    else $error("indicators changed on second set");

  a_ind_set: assert property (
    s_good_load and (sel && VARIANT == LCDSD_V60) |=> ##1
      INDICATOR_OUTPUT_A_OUT == $past(link_word[`LCDSD_IND_A_BIT], 2))
    else $error("indicator a not set");

  a_glitch_fail: assert property (
    load_evt && rise_cnt == 2'd2 |=> $stable(first_latch) && FRAME_REJECT_OUT)
    else $error("glitched frame accepted");

  a_slave_release: assert property (
    $rose(slave) |=> FIRST_BACKPLANE_OE_N_OUT && SECOND_BACKPLANE_OE_N_OUT)
    else $error("slave still drives backplane");

  a_seg_phase: assert property (
    !slave && !osc_slot && first_latch[0] && SEG_MASK[0] && $stable(first_latch)
      |=> SEGMENT_OUTPUTS_OUT[0] != FIRST_BACKPLANE_OUT)
    else $error("lit segment in phase with backplane");

  a_reset_clear: assert property (
    @(posedge CLK_SYS_IN) disable iff (1'b0)
    RST_IN |=> first_latch == 32'h00000000 && second_latch == 32'h00000000)
    else $error("reset left latches set");

endmodule

/* tb/lcdsd_host.sv */
module lcdsd_host (
  input  wire logic        go_in,
  input  wire logic [33:0] word_in,
  input  wire logic [5:0]  count_in,
  input  wire logic        glitch_in,
  input  wire logic        slow_in,
  output logic             burst_out,
  output logic             data_out,
  output logic             enable_out,
  output logic             done_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // ********************************
  // host side of the three-wire bus
  // ********************************
  int q;

  // idle bus: burst clock stands low, enable low
  initial begin
    burst_out = 1'h0;
    data_out = 1'h1;
    enable_out = 1'h0;
    done_out = 1'h1;
    q = 20;
  end

  // one frame per rising go; slow mode stretches every phase
  always @(posedge go_in) begin
    done_out = 1'h0;
    q = slow_in ? 80 : 20;
    // two idle pulses with enable low let the device's link reset run out
    repeat (2) begin
      #(q);
      burst_out = 1'h1;
      #(2 * q);
      burst_out = 1'h0;
      #(q);
    end
    enable_out = 1'h1;
    for (int i = 0; i < count_in; i++) begin
      data_out = (i < 34) ? word_in[i] : 1'h0;
      #(q);
      burst_out = 1'h1;
      #(q);
      // disturbance: falling-edge value differs from rising-edge one
      if (glitch_in && !slow_in && i == 7) data_out = ~data_out;
      #(q);
      burst_out = 1'h0;
      #(q);
      // slow disturbance: a short enable drop between pulses, unseen by the link
      if (glitch_in && slow_in && i == 7) begin
        enable_out = 1'h0;
        #(q / 2);
        enable_out = 1'h1;
      end
    end
    enable_out = 1'h0;
    data_out = ~data_out;  // released line must not hold its last value
    #(q);
    burst_out = 1'h1;
    #(2 * q);
    burst_out = 1'h0;
    #(q);
    done_out = 1'h1;
  end
endmodule

/* tb/testbench.sv */
module testbench import lcdsd_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  // ********************************
  // signals
  // ********************************
  logic        clk_sys, rst, burst, data, enable, osc_gnd, bp1_in, bp2_in;
  logic        bp1_out, oe1_n, bp2_out, oe2_n, ind_a, ind_b, reject;
  logic [31:0] seg;
  logic        go, glitch, slow, done;
  logic [33:0] word;
  logic [5:0]  cnt;
  logic [29:0] a_exp, b_exp;
  logic [1:0]  ind_exp;
  int          fails, compares, rejects;

  lcdsd_top #(.VARIANT(LCDSD_V60), .OSC_STEP_CYCLES(8)) dut_u (
    .CLK_SYS_IN               (clk_sys),
    .RST_IN                   (rst),
    .BURST_CLOCK_LINE_IN      (burst),
    .DATA_LINE_IN             (data),
    .LINE_ENABLE_IN           (enable),
    .OSC_GROUNDED_IN          (osc_gnd),
    .FIRST_BACKPLANE_IN       (bp1_in),
    .SECOND_BACKPLANE_IN      (bp2_in),
    .FIRST_BACKPLANE_OUT      (bp1_out),
    .FIRST_BACKPLANE_OE_N_OUT (oe1_n),
    .SECOND_BACKPLANE_OUT     (bp2_out),
    .SECOND_BACKPLANE_OE_N_OUT(oe2_n),
    .SEGMENT_OUTPUTS_OUT      (seg),
    .INDICATOR_OUTPUT_A_OUT   (ind_a),
    .INDICATOR_OUTPUT_B_OUT   (ind_b),
    .FRAME_REJECT_OUT         (reject)
  );

  lcdsd_host host_u (
    .go_in     (go),
    .word_in   (word),
    .count_in  (cnt),
    .glitch_in (glitch),
    .slow_in   (slow),
    .burst_out (burst),
    .data_out  (data),
    .enable_out(enable),
    .done_out  (done)
  );

  // 100 MHz system clock
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  // reject is a one-cycle pulse, so count it on every falling edge
  always @(negedge clk_sys) begin
    if (reject === 1'h1) rejects++;
  end

  // ********************************
  // shared tasks
  // ********************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [33:0] mk(input logic sel, input logic [1:0] ind,
                                     input logic [29:0] s);
    return {sel, ind, s, 1'h0};
  endfunction

  // one frame; 8 cycles after the load covers the 4-cycle latency
  task automatic send(input logic [33:0] w, input logic [5:0] n, input logic gl,
                      input logic sl);
    int k;
    @(negedge clk_sys);
    word = w;
    cnt = n;
    glitch = gl;
    slow = sl;
    go = 1'h1;
    @(negedge clk_sys);
    k = 0;
    while (done !== 1'h1 && k < 3000) begin
      @(negedge clk_sys);
      k++;
    end
    if (k >= 3000) begin
      fails++;
    end
    go = 1'h0;
    repeat (8) @(negedge clk_sys);
  endtask

  // both slots must show up; segment xor phase gives that slot's latch
  task automatic check_slots();
    logic [1:0] seen;
    seen = 2'h0;
    for (int k = 0; k < 64 && seen != 2'h3; k++) begin
      @(negedge clk_sys);
      if ((bp1_out ^ bp2_out) === 1'h0 && !seen[0]) begin
        check({2'h0, seg[29:0] ^ {30{bp1_out}}}, {2'h0, a_exp});
        seen[0] = 1'h1;
      end else if ((bp1_out ^ bp2_out) === 1'h1 && !seen[1]) begin
        check({2'h0, seg[29:0] ^ {30{bp1_out}}}, {2'h0, b_exp});
        seen[1] = 1'h1;
      end
    end
    check({30'h0, seen}, 32'h3);
    check({28'h0, oe1_n, oe2_n, seg[31:30]}, 32'h0);
    check({30'h0, ind_b, ind_a}, {30'h0, ind_exp});
  endtask

  // ********************************
  // scenarios
  // ********************************
  task automatic s_reject(input logic [33:0] w, input logic [5:0] n, input logic gl,
                          input logic sl);
    int r;
    r = rejects;
    send(w, n, gl, sl);
    check(32'(rejects - r), 32'h1);
    check_slots();
  endtask

  // slave: waveform follows the master pins, own drivers released
  task automatic s_slave();
    osc_gnd = 1'h1;
    bp1_in = 1'h1;
    bp2_in = 1'h0;
    repeat (6) @(negedge clk_sys);
    check({30'h0, oe1_n, oe2_n}, 32'h3);
    check({2'h0, seg[29:0]}, {2'h0, ~b_exp});
    bp1_in = 1'h0;
    repeat (6) @(negedge clk_sys);
    check({2'h0, seg[29:0]}, {2'h0, a_exp});
    osc_gnd = 1'h0;
    repeat (6) @(negedge clk_sys);
  endtask

  task automatic s_reset();
    rst = 1'h1;
    repeat (2) @(negedge clk_sys);
    check({seg[31:0]}, 32'h0);
    check({29'h0, ind_b, ind_a, reject}, 32'h0);
    rst = 1'h0;
    a_exp = 30'h0;
    b_exp = 30'h0;
    ind_exp = 2'h0;
    check_slots();
  endtask

  // ********************************
  // main sequence
  // ********************************
  initial begin
    rst <= 1'h1;
    osc_gnd = 1'h0;
    bp1_in = 1'h0;
    bp2_in = 1'h0;
    go = 1'h0;
    glitch = 1'h0;
    slow = 1'h0;
    word = 34'h0;
    cnt = 6'h22;
    fails = 0;
    compares = 0;
    rejects = 0;
    repeat (2) @(negedge clk_sys);
    rst = 1'h0;
    s_reset();
    a_exp = 30'h2aaaaaa5;
    ind_exp = 2'h1;
    send(mk(1'h1, 2'h1, a_exp), 6'h22, 1'h0, 1'h0);
    check_slots();
    b_exp = 30'h1c3c3c3c;
    send(mk(1'h0, 2'h2, b_exp), 6'h22, 1'h0, 1'h0);
    check_slots();
    s_reject(mk(1'h1, 2'h3, 30'h0) | 34'h1, 6'h22, 1'h0, 1'h0);
    s_reject(mk(1'h1, 2'h3, 30'h0), 6'h21, 1'h0, 1'h0);
    s_reject(mk(1'h1, 2'h3, 30'h0), 6'h23, 1'h0, 1'h0);
    s_reject(mk(1'h1, 2'h3, 30'h0), 6'h22, 1'h1, 1'h0);
    s_reject(mk(1'h1, 2'h3, 30'h0), 6'h22, 1'h1, 1'h1);
    a_exp = 30'h0f0f00ff;
    ind_exp = 2'h2;
    send(mk(1'h1, 2'h2, a_exp), 6'h22, 1'h0, 1'h1);
    check_slots();
    s_slave();
    s_reset();
    a_exp = 30'h3fffffff;
    ind_exp = 2'h3;
    send(mk(1'h1, 2'h3, a_exp), 6'h22, 1'h0, 1'h0);
    check_slots();
    test_done();
  end
endmodule
